//--- src/gpb_pkg.sv
// constants and types shared by the port b/c/d gpio block
package gpb_pkg;

  // ==========================================================================
  // bus geometry
  localparam int          ADDR_W        = 12;
  localparam int          DATA_W        = 32;
  localparam int          PORT_W        = 8;

  // ==========================================================================
  // register indexes, byte address is four times the index
  localparam logic [7:0]  IDX_PB_DATA   = 8'h01;
  localparam logic [7:0]  IDX_PC_DATA   = 8'h02;
  localparam logic [7:0]  IDX_PD_DATA   = 8'h03;
  localparam logic [7:0]  IDX_PB_DIR    = 8'h05;
  localparam logic [7:0]  IDX_PC_DIR    = 8'h06;
  localparam logic [7:0]  IDX_PD_DIR    = 8'h07;

  localparam logic [11:0] ADDR_PB_DATA  = {2'h0, IDX_PB_DATA, 2'h0};
  localparam logic [11:0] ADDR_PC_DATA  = {2'h0, IDX_PC_DATA, 2'h0};
  localparam logic [11:0] ADDR_PD_DATA  = {2'h0, IDX_PD_DATA, 2'h0};
  localparam logic [11:0] ADDR_PB_DIR   = {2'h0, IDX_PB_DIR, 2'h0};
  localparam logic [11:0] ADDR_PC_DIR   = {2'h0, IDX_PC_DIR, 2'h0};
  localparam logic [11:0] ADDR_PD_DIR   = {2'h0, IDX_PD_DIR, 2'h0};

  // ==========================================================================
  // field layout and reset values
  localparam logic [7:0]  DIR_RESET     = 8'h00;
  localparam int          PC_W          = 6;
  localparam int          PC_CLKEN_BIT  = 7;
  localparam int          PC_CLK_PIN    = 2;
  localparam int          PD_TA_PIN     = 6;
  localparam int          PD_TB_PIN     = 4;
  localparam int          PD_ADC_PINS   = 7;
  localparam logic [4:0]  ADC_PB_BASE   = 5'h00;
  localparam logic [4:0]  ADC_PD_BASE   = 5'h08;
  localparam logic [2:0]  PS_EXT_CLK    = 3'h7;

  // ==========================================================================
  // pad bundle: output level and active-low output enable
  typedef struct packed
  {
    logic [7:0] dout;
    logic [7:0] oe_n;
  } gpb_pad_s;

  // pad state under reset: undriven, low level
  localparam gpb_pad_s    PAD_IDLE      = '{dout: 8'h00, oe_n: 8'hff};

endpackage

//--- src/gpb_ports.sv
// gpio ports b, c and d with apb register access
`timescale 1ns/1ps

module gpb_ports
#(
  parameter int PB_ADC_CHANS = 8
)
(
  input  wire logic                    pclk,
  input  wire logic                    presetn,
  input  wire logic                    psel,
  input  wire logic                    penable,
  input  wire logic                    pwrite,
  input  wire logic [11:0]             paddr,
  input  wire logic [31:0]             pwdata,
  input  wire logic [3:0]              pstrb,
  output logic      [31:0]             prdata,
  output logic                         pready,
  output logic                         pslverr,
  input  wire logic [7:0]              pb_pin_in,
  input  wire logic [7:0]              pc_pin_in,
  input  wire logic [7:0]              pd_pin_in,
  output gpb_pkg::gpb_pad_s            pb_pad,
  output gpb_pkg::gpb_pad_s            pc_pad,
  output gpb_pkg::gpb_pad_s            pd_pad,
  input  wire logic [4:0]              adc_channel_select,
  input  wire logic [2:0]              timer_a_prescaler_select,
  input  wire logic [2:0]              timer_b_prescaler_select,
  output logic                         timer_a_ext_clock,
  output logic                         timer_b_ext_clock
);

  // ==========================================================================
  // register state
  logic [7:0]              port_b_data_latch_ff;
  logic [5:0]              port_c_data_latch_ff;
  logic [7:0]              port_d_data_latch_ff;
  logic [7:0]              port_b_direction_ff;
  logic [7:0]              port_c_direction_ff;
  logic [7:0]              port_d_direction_ff;
  logic                    sysclk_phase_ff;

  // bus answer flops
  logic [31:0]             prdata_ff;
  logic                    pready_ff;
  logic                    pslverr_ff;

  // pad and timer flops
  gpb_pkg::gpb_pad_s       pb_pad_ff;
  gpb_pkg::gpb_pad_s       pc_pad_ff;
  gpb_pkg::gpb_pad_s       pd_pad_ff;
  logic                    timer_a_ext_clock_ff;
  logic                    timer_b_ext_clock_ff;

  // ==========================================================================
  // bus decode
  logic                    setup_phase;
  logic                    access_done;
  logic                    wr_en;
  logic                    low_lane;
  logic                    hit_pb_data;
  logic                    hit_pc_data;
  logic                    hit_pd_data;
  logic                    hit_pb_dir;
  logic                    hit_pc_dir;
  logic                    hit_pd_dir;
  logic                    hit_any;
  logic [7:0]              wbyte;

  assign setup_phase = psel & ~penable;
  assign access_done = psel & penable & pready_ff;
  assign low_lane    = pstrb[0];
  assign wr_en       = access_done & pwrite & low_lane;
  assign wbyte       = pwdata[7:0];

  assign hit_pb_data = (paddr == gpb_pkg::ADDR_PB_DATA);
  assign hit_pc_data = (paddr == gpb_pkg::ADDR_PC_DATA);
  assign hit_pd_data = (paddr == gpb_pkg::ADDR_PD_DATA);
  assign hit_pb_dir  = (paddr == gpb_pkg::ADDR_PB_DIR);
  assign hit_pc_dir  = (paddr == gpb_pkg::ADDR_PC_DIR);
  assign hit_pd_dir  = (paddr == gpb_pkg::ADDR_PD_DIR);
  assign hit_any     = hit_pb_data | hit_pc_data | hit_pd_data
                     | hit_pb_dir | hit_pc_dir | hit_pd_dir;

  // ==========================================================================
  // alternate function ownership
  logic [7:0]              pb_adc_sel;
  logic [7:0]              pd_adc_sel;
  logic [7:0]              pd_timer_sel;
  logic                    ta_ext_sel;
  logic                    tb_ext_sel;
  logic                    sysclk_out_enable;

  genvar gi;
  generate
    for (gi = 0; gi < gpb_pkg::PORT_W; gi++)
    begin : g_adc
      if (gi < PB_ADC_CHANS)
      begin : g_pb
        assign pb_adc_sel[gi] = (adc_channel_select == (gpb_pkg::ADC_PB_BASE + 5'(gi)));
      end
      else
      begin : g_pb_none
        assign pb_adc_sel[gi] = 1'b0;
      end
      if (gi < gpb_pkg::PD_ADC_PINS)
      begin : g_pd
        assign pd_adc_sel[gi] = (adc_channel_select == (gpb_pkg::ADC_PD_BASE + 5'(gi)));
      end
      else
      begin : g_pd_none
        assign pd_adc_sel[gi] = 1'b0;
      end
    end
  endgenerate

  assign ta_ext_sel = (timer_a_prescaler_select == gpb_pkg::PS_EXT_CLK);
  assign tb_ext_sel = (timer_b_prescaler_select == gpb_pkg::PS_EXT_CLK);

  generate
    for (gi = 0; gi < gpb_pkg::PORT_W; gi++)
    begin : g_tmr
      if (gi == gpb_pkg::PD_TA_PIN)
      begin : g_ta
        assign pd_timer_sel[gi] = ta_ext_sel;
      end
      else if (gi == gpb_pkg::PD_TB_PIN)
      begin : g_tb
        assign pd_timer_sel[gi] = tb_ext_sel;
      end
      else
      begin : g_io
        assign pd_timer_sel[gi] = 1'b0;
      end
    end
  endgenerate

  assign sysclk_out_enable = port_c_direction_ff[gpb_pkg::PC_CLKEN_BIT];

  // ==========================================================================
  // pin drive
  logic [7:0]              nxt_pb_oe;
  logic [7:0]              nxt_pd_oe;
  logic [7:0]              nxt_pc_oe;
  logic [7:0]              nxt_pc_dout;
  logic [7:0]              pc_latch_wide;

  assign nxt_pb_oe = port_b_direction_ff & ~pb_adc_sel;
  assign nxt_pd_oe = port_d_direction_ff & ~pd_adc_sel & ~pd_timer_sel;

  assign pc_latch_wide = {2'h0, port_c_data_latch_ff};

  always_comb
  begin
    nxt_pc_oe   = {2'h0, port_c_direction_ff[gpb_pkg::PC_W-1:0]};
    nxt_pc_dout = pc_latch_wide;
    if (sysclk_out_enable)
    begin
      nxt_pc_oe[gpb_pkg::PC_CLK_PIN]   = 1'b1;
      nxt_pc_dout[gpb_pkg::PC_CLK_PIN] = sysclk_phase_ff;
    end
  end

  // ==========================================================================
  // read data
  logic [7:0]              rd_pb;
  logic [7:0]              rd_pc;
  logic [7:0]              rd_pd;
  logic [7:0]              rd_byte;

  assign rd_pb = (port_b_direction_ff & port_b_data_latch_ff)
               | (~port_b_direction_ff & ~pb_adc_sel & pb_pin_in);

  // latch or pin, upper bits zero
  assign rd_pc = {2'h0, (port_c_direction_ff[gpb_pkg::PC_W-1:0] & port_c_data_latch_ff)
                      | (~port_c_direction_ff[gpb_pkg::PC_W-1:0] & pc_pin_in[gpb_pkg::PC_W-1:0])};

  assign rd_pd = (port_d_direction_ff & port_d_data_latch_ff)
               | (~port_d_direction_ff & ~pd_adc_sel & pd_pin_in);

  assign rd_byte = hit_pb_data ? rd_pb
                 : hit_pc_data ? rd_pc
                 : hit_pd_data ? rd_pd
                 : hit_pb_dir  ? port_b_direction_ff
                 : hit_pc_dir  ? port_c_direction_ff
                 : hit_pd_dir  ? port_d_direction_ff
                 : 8'h00;

  // ==========================================================================
  // bus answer: one wait-free access phase, data captured at setup
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata_ff  <= 32'h0000_0000;
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
    end
    else
    begin
      pready_ff  <= setup_phase;
      pslverr_ff <= setup_phase & ~hit_any;
      if (setup_phase)
      begin
        prdata_ff <= pwrite ? 32'h0000_0000 : {24'h00_0000, rd_byte};
      end
    end
  end

  // ==========================================================================
  // data latches, no reset
  // port c latches keep value over reset
  // port d latches keep value over reset
  always_ff @(posedge pclk)
  begin
    if (wr_en && hit_pb_data)
    begin
      port_b_data_latch_ff <= wbyte;
    end
    if (wr_en && hit_pc_data)
    begin
      port_c_data_latch_ff <= wbyte[gpb_pkg::PC_W-1:0];
    end
    if (wr_en && hit_pd_data)
    begin
      port_d_data_latch_ff <= wbyte;
    end
  end

  // ==========================================================================
  // direction registers
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      port_b_direction_ff <= gpb_pkg::DIR_RESET;
      // port c and clock out cleared
      port_c_direction_ff <= gpb_pkg::DIR_RESET;
      port_d_direction_ff <= gpb_pkg::DIR_RESET;
    end
    else
    begin
      if (wr_en && hit_pb_dir)
      begin
        port_b_direction_ff <= wbyte;
      end
      // bit 6 is not implemented
      if (wr_en && hit_pc_dir)
      begin
        port_c_direction_ff <= {wbyte[gpb_pkg::PC_CLKEN_BIT], 1'b0, wbyte[gpb_pkg::PC_W-1:0]};
      end
      if (wr_en && hit_pd_dir)
      begin
        port_d_direction_ff <= wbyte;
      end
    end
  end

  // ==========================================================================
  // system clock out, half rate toggle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sysclk_phase_ff <= 1'b0;
    end
    else
    begin
      sysclk_phase_ff <= ~sysclk_phase_ff;
    end
  end

  // ==========================================================================
  // pad flops, one process per port
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pb_pad_ff <= gpb_pkg::PAD_IDLE;
    end
    else
    begin
      pb_pad_ff <= '{dout: port_b_data_latch_ff, oe_n: ~nxt_pb_oe};
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pc_pad_ff <= gpb_pkg::PAD_IDLE;
    end
    else
    begin
      pc_pad_ff <= '{dout: nxt_pc_dout, oe_n: ~nxt_pc_oe};
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pd_pad_ff <= gpb_pkg::PAD_IDLE;
    end
    else
    begin
      pd_pad_ff <= '{dout: port_d_data_latch_ff, oe_n: ~nxt_pd_oe};
    end
  end

  // ==========================================================================
  // timer external clocks
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      timer_a_ext_clock_ff <= 1'b0;
      timer_b_ext_clock_ff <= 1'b0;
    end
    else
    begin
      timer_a_ext_clock_ff <= ta_ext_sel & pd_pin_in[gpb_pkg::PD_TA_PIN];
      timer_b_ext_clock_ff <= tb_ext_sel & pd_pin_in[gpb_pkg::PD_TB_PIN];
    end
  end

  // ==========================================================================
  // outputs
  assign prdata            = prdata_ff;
  assign pready            = pready_ff;
  assign pslverr           = pslverr_ff;
  assign pb_pad            = pb_pad_ff;
  assign pc_pad            = pc_pad_ff;
  assign pd_pad            = pd_pad_ff;
  assign timer_a_ext_clock = timer_a_ext_clock_ff;
  assign timer_b_ext_clock = timer_b_ext_clock_ff;

endmodule

//--- tb/gpb_pin_env.sv
// external pin model for ports b, c and d
`timescale 1ns/1ps

module gpb_pin_env
(
  input  gpb_pkg::gpb_pad_s pb_pad,
  input  gpb_pkg::gpb_pad_s pc_pad,
  input  gpb_pkg::gpb_pad_s pd_pad,
  input  wire logic [7:0]   pb_ext,
  input  wire logic [7:0]   pc_ext,
  input  wire logic [7:0]   pd_ext,
  output logic [7:0]        pb_pin,
  output logic [7:0]        pc_pin,
  output logic [7:0]        pd_pin
);
  // ==========
  // weak board drive, overridden wherever the pad drives
  function automatic logic [7:0] level(input gpb_pkg::gpb_pad_s pad, input logic [7:0] ext);
    level = (pad.dout & ~pad.oe_n) | (ext & pad.oe_n);
  endfunction

  assign pb_pin = level(pb_pad, pb_ext);
  assign pc_pin = level(pc_pad, pc_ext);
  assign pd_pin = level(pd_pad, pd_ext);
endmodule

//--- tb/gpb_ports_bench.sv
// self-checking bench for the gpio block
`timescale 1ns/1ps

module gpb_ports_bench;
  logic              pclk, presetn, psel, penable, pwrite, pready, pslverr, ta_clk, tb_clk;
  logic [11:0]       paddr;
  logic [31:0]       pwdata, prdata;
  logic [3:0]        pstrb;
  logic [4:0]        adc_sel;
  logic [2:0]        ps_a, ps_b;
  logic [7:0]        pb_in, pc_in, pd_in, pb_ext, pc_ext, pd_ext;
  gpb_pkg::gpb_pad_s pb_pad, pc_pad, pd_pad;
  int                n_fail, num_checks;

  gpb_ports u_gpb_ports (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pb_pin_in(pb_in), .pc_pin_in(pc_in), .pd_pin_in(pd_in), .pb_pad(pb_pad), .pc_pad(pc_pad),
    .pd_pad(pd_pad), .adc_channel_select(adc_sel), .timer_a_prescaler_select(ps_a),
    .timer_b_prescaler_select(ps_b), .timer_a_ext_clock(ta_clk), .timer_b_ext_clock(tb_clk));
  gpb_pin_env u_gpb_pin_env (.pb_pad(pb_pad), .pc_pad(pc_pad), .pd_pad(pd_pad), .pb_ext(pb_ext),
    .pc_ext(pc_ext), .pd_ext(pd_ext), .pb_pin(pb_in), .pc_pin(pc_in), .pd_pin(pd_in));

  // ==========
  // clock and shared tasks
  initial
  begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      n_fail++;
    end
  endtask

  task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d, input logic [3:0] s,
                     output logic [31:0] r, output logic e);
    @(posedge pclk);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= {24'h0, d};
    pstrb   <= s;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    r = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, d, 4'h1, r, e);
  endtask

  task automatic rd(input logic [11:0] a, input logic [7:0] x);
    logic [31:0] r;
    logic        e;
    apb(1'b0, a, 8'h0, 4'h0, r, e);
    chk(r[7:0], x);
    chk({7'h0, e}, 8'h00);
  endtask

  task automatic settle;
    repeat (4) @(posedge pclk);
    #1;
  endtask

  task automatic end_of_test;
    $display("checks %0d, mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // ==========
  // scenarios
  task automatic t_port_b;
    logic [31:0] r;
    logic        e;
    settle;
    chk(pb_pad.oe_n, 8'hff);
    rd(gpb_pkg::ADDR_PD_DIR, 8'h00);
    wr(gpb_pkg::ADDR_PB_DATA, 8'ha5);
    wr(gpb_pkg::ADDR_PB_DIR, 8'h0f);
    settle;
    chk(pb_pad.oe_n, 8'hf0);
    chk(pb_pad.dout & 8'h0f, 8'h05);
    rd(gpb_pkg::ADDR_PB_DATA, 8'h35);
    adc_sel <= 5'h01;
    settle;
    chk(pb_pad.oe_n, 8'hf2);
    rd(gpb_pkg::ADDR_PB_DATA, 8'h35);
    adc_sel <= 5'h05;
    rd(gpb_pkg::ADDR_PB_DATA, 8'h15);
    adc_sel <= 5'h1f;
    wr(gpb_pkg::ADDR_PB_DATA, 8'hff);
    settle;
    chk(pb_pad.oe_n, 8'hf0);
    rd(gpb_pkg::ADDR_PB_DATA, 8'h3f);
    apb(1'b0, 12'h020, 8'h0, 4'h0, r, e);
    chk({7'h0, e}, 8'h01);
    apb(1'b1, gpb_pkg::ADDR_PB_DIR, 8'hff, 4'h0, r, e);
    rd(gpb_pkg::ADDR_PB_DIR, 8'h0f);
  endtask

  task automatic t_port_c;
    logic b;
    wr(gpb_pkg::ADDR_PC_DATA, 8'h2d);
    wr(gpb_pkg::ADDR_PC_DIR, 8'h07);
    settle;
    chk(pc_pad.oe_n, 8'hf8);
    chk(pc_pad.dout & 8'h07, 8'h05);
    rd(gpb_pkg::ADDR_PC_DATA, 8'h15);
    wr(gpb_pkg::ADDR_PC_DIR, 8'hfb);
    rd(gpb_pkg::ADDR_PC_DIR, 8'hbb);
    settle;
    chk(pc_pad.oe_n, 8'hc0);
    b = pc_pad.dout[2];
    @(posedge pclk);
    #1;
    chk({7'h0, b ^ pc_pad.dout[2]}, 8'h01);
  endtask

  task automatic t_port_d;
    wr(gpb_pkg::ADDR_PD_DATA, 8'h5a);
    wr(gpb_pkg::ADDR_PD_DIR, 8'hf0);
    settle;
    chk(pd_pad.oe_n, 8'h0f);
    chk(pd_pad.dout & 8'hf0, 8'h50);
    rd(gpb_pkg::ADDR_PD_DATA, 8'h53);
    adc_sel <= 5'h08;
    rd(gpb_pkg::ADDR_PD_DATA, 8'h52);
    adc_sel <= 5'h1f;
    ps_a    <= 3'h7;
    ps_b    <= 3'h7;
    settle;
    chk(pd_pad.oe_n, 8'h5f);
    rd(gpb_pkg::ADDR_PD_DATA, 8'h53);
    chk({6'h0, ta_clk, tb_clk}, 8'h01);
    @(posedge pclk);
    pd_ext <= 8'h63;
    ps_b   <= 3'h0;
    settle;
    chk({6'h0, ta_clk, tb_clk}, 8'h02);
    chk(pd_pad.oe_n, 8'h4f);
  endtask

  task automatic t_latch_keep;
    @(posedge pclk);
    presetn <= 1'b0;
    ps_a    <= 3'h0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    settle;
    chk(pc_pad.oe_n, 8'hff);
    rd(gpb_pkg::ADDR_PC_DIR, 8'h00);
    wr(gpb_pkg::ADDR_PC_DIR, 8'h3f);
    wr(gpb_pkg::ADDR_PD_DIR, 8'hff);
    rd(gpb_pkg::ADDR_PC_DATA, 8'h2d);
    rd(gpb_pkg::ADDR_PD_DATA, 8'h5a);
  endtask

  // ==========
  // main sequence and watchdog
  initial
  begin
    {presetn, psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
    {ps_a, ps_b, n_fail, num_checks} = '0;
    adc_sel = 5'h1f;
    pb_ext  = 8'h3c;
    pc_ext  = 8'hd5;
    pd_ext  = 8'h33;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    t_port_b;
    t_port_c;
    t_port_d;
    t_latch_keep;
    end_of_test;
  end

  initial
  begin
    #100000;
    n_fail++;
    end_of_test;
  end
endmodule

//--- tb/gpb_ports_chk.sv
// concurrent checks on the gpio block ports
`timescale 1ns/1ps

module gpb_ports_chk
(
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input gpb_pkg::gpb_pad_s pb_pad,
  input gpb_pkg::gpb_pad_s pc_pad,
  input gpb_pkg::gpb_pad_s pd_pad,
  input wire logic [7:0]  pd_pin_in,
  input wire logic [4:0]  adc_channel_select,
  input wire logic [2:0]  timer_a_prescaler_select,
  input wire logic        timer_a_ext_clock
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // ==========
  // bus and pads
  property p_one_access; psel && !penable |=> pready; endproperty
  a_one_access: assert property (p_one_access) else $error("ready late");
  property p_ready_pulse; pready |=> !pready; endproperty
  a_ready_pulse: assert property (p_ready_pulse) else $error("ready too long");
  property p_upper_zero; pready && !pwrite |-> prdata[31:8] == 24'h0; endproperty
  a_upper_zero: assert property (p_upper_zero) else $error("upper read bits set");
  property p_pc_unused; pc_pad.oe_n[7:6] == 2'h3 && pc_pad.dout[7:6] == 2'h0; endproperty
  a_pc_unused: assert property (p_pc_unused) else $error("port c top pads active");
  property p_reset_inputs;
    $rose(presetn) |-> pb_pad.oe_n == 8'hff && pc_pad.oe_n == 8'hff && pd_pad.oe_n == 8'hff;
  endproperty
  a_reset_inputs: assert property (p_reset_inputs) else $error("pad driven after reset");
  property p_adc_b; adc_channel_select < 5'h08 |=> pb_pad.oe_n[$past(adc_channel_select[2:0])]; endproperty
  a_adc_b: assert property (p_adc_b) else $error("adc pin b driven");
  property p_adc_d;
    adc_channel_select inside {[5'h08:5'h0e]} |=> pd_pad.oe_n[$past(adc_channel_select[2:0])];
  endproperty
  a_adc_d: assert property (p_adc_d) else $error("adc pin d driven");
  property p_ta_pin; timer_a_prescaler_select == 3'h7 |=> pd_pad.oe_n[6]; endproperty
  a_ta_pin: assert property (p_ta_pin) else $error("timer pin driven");
  property p_ta_clk;
    1'b1 |=> timer_a_ext_clock == ($past(timer_a_prescaler_select) == 3'h7 && $past(pd_pin_in[6]));
  endproperty
  a_ta_clk: assert property (p_ta_clk) else $error("timer clock wrong");
  c_adc_b: cover property (adc_channel_select < 5'h08 && pready);
  c_ta_clk: cover property ($rose(timer_a_ext_clock));
  c_reset: cover property ($rose(presetn));
endmodule

bind gpb_ports gpb_ports_chk u_gpb_ports_chk
(
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .prdata(prdata),
  .pready(pready), .pb_pad(pb_pad), .pc_pad(pc_pad), .pd_pad(pd_pad), .pd_pin_in(pd_pin_in),
  .adc_channel_select(adc_channel_select), .timer_a_prescaler_select(timer_a_prescaler_select),
  .timer_a_ext_clock(timer_a_ext_clock)
);
